// *** src/rx_pkg.sv ***
// Purpose: shared constants and types for the serial word to byte receiver
// Assumes: all inputs synchronous to mclk
// Notes: bit 1 of a serial word lands in buffer bit 0
package rx_pkg;
    localparam int WORD_BITS = 32;
    localparam logic [5:0] WORD_BITS_CNT = 6'h20;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3f;
    localparam int BYTE_W = 8;
    localparam logic [1:0] FIRST_BYTE = 2'h0;
    localparam logic [1:0] LAST_BYTE = 2'h3;
    localparam int PARITY_POS = 31;
    localparam logic [4:0] GAP_TICKS = 5'h10;
    localparam logic [4:0] GAP_LAST_TICK = 5'h0f;

    typedef struct packed {
        logic one;
        logic zero;
    } rail_t;

    typedef enum logic {ST_INIT, ST_RUN} rx_state_t;
endpackage : rx_pkg

// *** src/rail_front.sv ***
// Purpose: rail source select, one/zero/null latches and bit strobe
// Assumes: rails are digital levels synchronous to mclk
// Notes: both bypass rails high count as null; both serial or line rails high hold the latch
`timescale 1ns/10ps
module rail_front (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic integrated_receiver_sel,
    input wire rx_pkg::rail_t serial_rails,
    input wire rx_pkg::rail_t line_rails,
    input wire rx_pkg::rail_t bypass_rails,
    output logic bit_stb,
    output logic bit_val
);
    import rx_pkg::*;

    rail_t raw;
    rail_t latch_q;
    logic any_q;

    // any bypass input high takes over from the line receiver
    always_comb begin
        if (!integrated_receiver_sel) begin
            raw = serial_rails;
        end else if (bypass_rails.one || bypass_rails.zero) begin
            raw.one = bypass_rails.one & ~bypass_rails.zero;
            raw.zero = bypass_rails.zero & ~bypass_rails.one;
        end else begin
            raw = line_rails;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            latch_q <= '0;
        end else if (!raw.one && !raw.zero) begin
            latch_q <= '0;
        end else if (raw.one && !raw.zero) begin
            latch_q <= '{one: 1'b1, zero: 1'b0};
        end else if (raw.zero && !raw.one) begin
            latch_q <= '{one: 1'b0, zero: 1'b1};
        end
    end

    // bit clock is the start of each one or zero pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            any_q <= 1'b0;
            bit_stb <= 1'b0;
            bit_val <= 1'b0;
        end else begin
            any_q <= latch_q.one | latch_q.zero;
            bit_stb <= (latch_q.one | latch_q.zero) & ~any_q;
            bit_val <= latch_q.one;
        end
    end
endmodule : rail_front

// *** src/gap_timer.sv ***
// Purpose: word gap detection timed on the gap timebase input
// Assumes: timebase is slower than half the mclk rate
// Notes: one gap pulse per idle stretch; restarts on every bit
`timescale 1ns/10ps
module gap_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic word_gap_timebase,
    input wire logic bit_stb,
    output logic gap_stb
);
    import rx_pkg::*;

    logic tb_q;
    logic tick;
    logic [4:0] cnt_q;

    assign tick = word_gap_timebase & ~tb_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tb_q <= 1'b0;
        end else begin
            tb_q <= word_gap_timebase;
        end
    end

    // bit phase is free against the timebase, so the gap is 15 to 16 tick periods
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (bit_stb) begin
            cnt_q <= '0;
        end else if (tick && cnt_q != GAP_TICKS) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gap_stb <= 1'b0;
        end else begin
            gap_stb <= tick & ~bit_stb & (cnt_q == GAP_LAST_TICK);
        end
    end
endmodule : gap_timer

// *** src/word_receiver.sv ***
// Purpose: serial two-rail word receiver with a byte-wide host read port
// Assumes: all inputs synchronous to mclk; read strobe held low >= 2 cycles
// Notes: byte pointer advances when the read strobe returns high
// Behaviour
// - shift bits, check, then load 32-bit buffer
// - host reads buffer while next word shifts
// - recover bits from two rails into register
// - integrated variant selects receiver or bypass rails
// - valid level sets rail latch, null clears
// - bypass inputs together replace receiver outputs
// - gap after 16 idle timebase cycles
// - gap interval may span 16 to 17; timer gives 15 to 16 (gap on 16th tick)
// - ready high until first byte read
// - strobe low drives current byte on bus
// - parity select replaces bit 32 with error
// - error on bit count or enabled parity
// - reset low initialises all logic
// - four reads give bits 1-32 in order
// - new word overwrites, pointer and ready reset
// - error set at gap, cleared by good word
// - after reset wait for first gap
`timescale 1ns/10ps
module word_receiver (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic integrated_receiver_sel,
    input wire logic serial_high_rail_in,
    input wire logic serial_low_rail_in,
    input wire logic line_positive_in,
    input wire logic line_negative_in,
    input wire logic bypass_rail_one_in,
    input wire logic bypass_rail_zero_in,
    input wire logic word_gap_timebase,
    input wire logic odd_parity_check_select,
    input wire logic read_strobe_n,
    output logic [rx_pkg::BYTE_W-1:0] host_byte_bus_out,
    output logic host_byte_bus_oe,
    output logic word_ready,
    output logic word_error
);
    import rx_pkg::*;

    logic bit_stb;
    logic bit_val;
    logic gap_stb;
    rx_state_t state_q;
    logic [WORD_BITS-1:0] shift_q;
    logic [5:0] bit_cnt_q;
    logic [WORD_BITS-1:0] buf_q;
    logic [1:0] ptr_q;
    logic strobe_q;
    logic read_fall;
    logic read_rise;
    logic load;
    logic par_err;
    logic good;
    logic [BYTE_W-1:0] sel_byte;

    rail_front u_rail (
        .mclk(mclk),
        .rst_n(rst_n),
        .integrated_receiver_sel(integrated_receiver_sel),
        .serial_rails('{one: serial_high_rail_in, zero: serial_low_rail_in}),
        .line_rails('{one: line_positive_in, zero: line_negative_in}),
        .bypass_rails('{one: bypass_rail_one_in, zero: bypass_rail_zero_in}),
        .bit_stb(bit_stb),
        .bit_val(bit_val)
    );

    gap_timer u_gap (
        .mclk(mclk),
        .rst_n(rst_n),
        .word_gap_timebase(word_gap_timebase),
        .bit_stb(bit_stb),
        .gap_stb(gap_stb)
    );

    // odd parity fails when the word holds an even count of ones
    assign par_err = ~^shift_q;
    assign good = (bit_cnt_q == WORD_BITS_CNT) & ~(odd_parity_check_select & par_err);
    assign load = gap_stb & (state_q == ST_RUN) & (bit_cnt_q != '0);
    assign read_fall = strobe_q & ~read_strobe_n;
    assign read_rise = ~strobe_q & read_strobe_n;
    assign sel_byte = buf_q[ptr_q*BYTE_W +: BYTE_W];

    // stay idle after reset until a gap, so no partial word is taken
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_INIT;
        end else begin
            case (state_q)
                ST_INIT: if (gap_stb) state_q <= ST_RUN;
                ST_RUN: state_q <= ST_RUN;
                default: state_q <= ST_INIT;
            endcase
        end
    end

    // first bit received ends in bit 0
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shift_q <= '0;
        end else if (bit_stb) begin
            shift_q <= {bit_val, shift_q[WORD_BITS-1:1]};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bit_cnt_q <= '0;
        end else if (gap_stb) begin
            bit_cnt_q <= '0;
        end else if (bit_stb && bit_cnt_q != BIT_CNT_MAX) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    // buffer loads on every word, readable while the next one shifts in
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            buf_q <= '0;
        end else if (load) begin
            buf_q[PARITY_POS-1:0] <= shift_q[PARITY_POS-1:0];
            buf_q[PARITY_POS] <= odd_parity_check_select ? par_err
                                                         : shift_q[PARITY_POS];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            word_error <= 1'b0;
        end else if (load) begin
            word_error <= ~good;
        end
    end

    // a new word wins over a read in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            word_ready <= 1'b0;
        end else if (load) begin
            word_ready <= 1'b1;
        end else if (read_fall && ptr_q == FIRST_BYTE) begin
            word_ready <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ptr_q <= FIRST_BYTE;
        end else if (load) begin
            ptr_q <= FIRST_BYTE;
        end else if (read_rise && ptr_q != LAST_BYTE) begin
            ptr_q <= ptr_q + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strobe_q <= 1'b1;
            host_byte_bus_out <= '0;
        end else begin
            strobe_q <= read_strobe_n;
            host_byte_bus_out <= sel_byte;
        end
    end

    assign host_byte_bus_oe = ~read_strobe_n;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);

    bus_data_a: assert property (!read_strobe_n && !$past(read_strobe_n) && !$past(load)
        |-> host_byte_bus_oe && host_byte_bus_out == $past(sel_byte))
        else $error("bus byte does not match buffer byte");
    bus_release_a: assert property (read_strobe_n |-> !host_byte_bus_oe)
        else $error("bus driven with strobe high");
    ready_rise_a: assert property (load |=> word_ready && ptr_q == FIRST_BYTE)
        else $error("new word did not raise ready and rewind pointer");
    ready_drop_a: assert property (read_fall && ptr_q == FIRST_BYTE && !load
        |=> !word_ready)
        else $error("ready stayed high after first byte read");
    ptr_step_a: assert property (read_rise && !load && ptr_q != LAST_BYTE
        |=> ptr_q == $past(ptr_q) + 2'h1)
        else $error("byte pointer did not advance");
    error_len_a: assert property (load && bit_cnt_q != WORD_BITS_CNT |=> word_error)
        else $error("bit count error not flagged");
    error_clear_a: assert property (load && good |=> !word_error [*2] or load)
        else $error("good word did not clear error");
    parity_bit_a: assert property (load && odd_parity_check_select
        |=> buf_q[PARITY_POS] == $past(par_err) && word_error == !$past(good))
        else $error("parity bit not replaced by error result");
    init_hold_a: assert property (state_q == ST_INIT |-> !load)
        else $error("word loaded before first gap");
    shift_in_a: assert property (bit_stb |=> shift_q[WORD_BITS-1] == $past(bit_val))
        else $error("received bit not shifted in");

    good_word_c: cover property (load && good);
    bad_word_c: cover property (load && !good);
    four_reads_c: cover property (word_ready ##1 (ptr_q == LAST_BYTE && read_fall));
    overwrite_c: cover property (ptr_q != FIRST_BYTE && load);
    parity_err_c: cover property (load && odd_parity_check_select && par_err);
endmodule : word_receiver

// *** verification/host_reader.sv ***
// Purpose: host side model that fetches bytes with the read strobe
// Assumes: strobe low lasts three clocks, high lasts four between back-to-back reads
// Notes: the byte is taken at the last edge of the low phase
`timescale 1ns/10ps
module host_reader (
    input wire logic mclk,
    input wire logic [7:0] host_byte_bus,
    output logic read_strobe_n
);
    initial read_strobe_n = 1'b1;
    task automatic read_byte(output logic [7:0] b);
        @(posedge mclk);
        #1 read_strobe_n = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        b = host_byte_bus;
        read_strobe_n = 1'b1;
        repeat (3) @(posedge mclk);
    endtask : read_byte
endmodule : host_reader

// *** verification/word_receiver_bench.sv ***
// Purpose: self-checking bench for the serial word receiver
// Assumes: gap timebase runs at a quarter of the mclk rate
// Notes: each bit is two clocks of level then two clocks of null
`timescale 1ns/10ps
module word_receiver_bench;
    import rx_pkg::*;
    logic mclk, rst_n, src_sel, hi_r, lo_r, lp, ln, b1, b0, par_sel, read_strobe_n, oe;
    logic word_ready, word_error;
    logic [1:0] tb_cnt;
    logic [BYTE_W-1:0] bus_out;
    wire [BYTE_W-1:0] host_byte_bus;
    int src, n_mismatch, num_checks;
    // a released bus shows the inverse so a stale byte never matches
    assign host_byte_bus = oe ? bus_out : ~bus_out;
    word_receiver u_dut (.mclk(mclk), .rst_n(rst_n), .integrated_receiver_sel(src_sel),
        .serial_high_rail_in(hi_r), .serial_low_rail_in(lo_r), .line_positive_in(lp),
        .line_negative_in(ln), .bypass_rail_one_in(b1), .bypass_rail_zero_in(b0),
        .word_gap_timebase(tb_cnt[1]), .odd_parity_check_select(par_sel),
        .read_strobe_n(read_strobe_n), .host_byte_bus_out(bus_out), .host_byte_bus_oe(oe),
        .word_ready(word_ready), .word_error(word_error));
    host_reader u_host (.mclk(mclk), .host_byte_bus(host_byte_bus),
        .read_strobe_n(read_strobe_n));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) tb_cnt <= tb_cnt + 2'h1;
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask : tick
    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : check_word
    task automatic check_bit(input string name, input logic e, input logic g);
        check_word(name, {31'h0, e}, {31'h0, g});
    endtask : check_bit
    task automatic rails(input logic one, input logic zero);
        src_sel = (src != 0);
        {hi_r, lo_r} = (src == 0) ? {one, zero} : 2'h0;
        {lp, ln} = (src == 1) ? {one, zero} : 2'h0;
        {b1, b0} = (src != 2) ? 2'h0 : (one | zero) ? {one, zero} : 2'h3;
    endtask : rails
    task automatic send_word(input logic [31:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            rails(w[i % 32], ~w[i % 32]);
            repeat (2) tick();
            rails(1'b0, 1'b0);
            repeat (2) tick();
        end
        // gap needs 15 to 16 timebase periods of four clocks
        repeat (100) tick();
    endtask : send_word
    task automatic read_word(output logic [31:0] w);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            u_host.read_byte(b);
            w[i*8 +: 8] = b;
            if (i == 0) check_bit("ready", 1'b0, word_ready);
        end
        check_bit("bus enable", 1'b0, oe);
    endtask : read_word
    task automatic rx_and_check(input logic [31:0] w, input int n, input logic [31:0] e,
            input logic err);
        logic [31:0] got;
        send_word(w, n);
        check_bit("ready", 1'b1, word_ready);
        check_bit("error", err, word_error);
        read_word(got);
        if (n == 32) check_word("word", e, got);
    endtask : rx_and_check
    task automatic t_reset;
        send_word(32'h0000_0001, 31);
        rst_n = 1'b0;
        repeat (2) tick();
        rst_n = 1'b1;
        check_bit("ready", 1'b0, word_ready);
        check_bit("error", 1'b0, word_error);
        send_word(32'h0000_00ff, 32);
        check_bit("ready", 1'b0, word_ready);
        rx_and_check(32'h7e00_0081, 32, 32'h7e00_0081, 1'b0);
    endtask : t_reset
    task automatic t_sources;
        logic [31:0] w;
        for (int s = 0; s < 3; s++) begin
            src = s;
            w = 32'h8a5c_13e7 ^ s;
            rails(1'b0, 1'b0);
            repeat (2) tick();
            rx_and_check(w, 32, w, 1'b0);
        end
        src = 0;
        rails(1'b0, 1'b0);
    endtask : t_sources
    task automatic t_counts;
        rx_and_check(32'h0000_0f0f, 31, 32'h0, 1'b1);
        rx_and_check(32'h0000_0f0f, 33, 32'h0, 1'b1);
        rx_and_check(32'h0000_0f0f, 32, 32'h0000_0f0f, 1'b0);
    endtask : t_counts
    task automatic t_parity;
        logic [31:0] w[4];
        w = '{32'h0000_0007, 32'h0000_000f, 32'h8000_0003, 32'h8000_0001};
        for (int i = 0; i < 4; i++) begin
            par_sel = (i < 3);
            rx_and_check(w[i], 32, {par_sel ? ~^w[i] : w[i][31], w[i][30:0]},
                par_sel & ~^w[i]);
        end
    endtask : t_parity
    task automatic t_overwrite;
        logic [7:0] b;
        logic [31:0] a, got;
        a = 32'h1122_3344;
        send_word(a, 32);
        u_host.read_byte(b);
        check_word("byte", {24'h0, a[7:0]}, {24'h0, b});
        fork
            send_word(32'hcafe_0b0e, 32);
            for (int i = 1; i < 3; i++) begin
                u_host.read_byte(b);
                check_word("byte", {24'h0, a[i*8 +: 8]}, {24'h0, b});
            end
        join
        check_bit("ready", 1'b1, word_ready);
        read_word(got);
        check_word("word", 32'hcafe_0b0e, got);
    endtask : t_overwrite
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        #3000000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        tb_cnt = 2'h0;
        src = 0;
        par_sel = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        rails(1'b0, 1'b0);
        repeat (10) tick();
        rst_n = 1'b1;
        t_reset();
        t_sources();
        t_counts();
        t_parity();
        t_overwrite();
        stop_test();
    end
endmodule : word_receiver_bench
